//--- core/sadc_pkg.sv
// shared constants and types of the converter readout block
package sadc_pkg;

    // ****************************************
    // clock and conversion timing
    // ****************************************
    localparam int MCLK_PERIOD_NS = 4;
    localparam int CONV_MIN_NS = 500;
    localparam int CONV_MAX_NS = 710;
    // nominal internal conversion time, kept inside the min/max bounds
    localparam int CONV_NS = 600;
    localparam int CONV_CYCLES = (CONV_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CONV_CNT_W = 8;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST =
        CONV_CNT_W'(CONV_CYCLES - 1);

    // ****************************************
    // result and frame layout
    // ****************************************
    localparam int RESULT_W = 16;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
    localparam int FALL_W = 5;
    localparam logic [FALL_W-1:0] FRAME_PLAIN = 5'h10;
    localparam logic [FALL_W-1:0] FRAME_BUSY = 5'h11;
    localparam logic [FALL_W-1:0] MSB_INDEX = 5'h0f;
    localparam logic [FALL_W-1:0] BUSY_MSB_INDEX = 5'h10;
    localparam logic BUSY_LEVEL = 1'b0;

    // ****************************************
    // sequencer states, one-hot
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CONV  = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_SHIFT = 4'b1000
    } sadc_state_t;

    // ****************************************
    // status carried out of the block
    // ****************************************
    typedef struct packed {
        logic converting;
        logic acquiring;
        logic daisy_mode;
        logic busy_option;
    } sadc_status_t;

    typedef struct packed {
        logic data;
        logic drive;
    } sadc_pin_t;

endpackage

//--- core/sadc_fall_counter.sv
// serial clock falling-edge counter, gray-coded into the mclk domain
`timescale 1ns/1ps
module sadc_fall_counter
    import sadc_pkg::*;
(
    input wire logic mclk, // core clock
    input wire logic reset, // async reset, active high
    input wire logic sclk, // serial clock from the host
    output logic [FALL_W-1:0] fall_count // falls seen, mclk domain
);

    // ****************************************
    // link side: counts on every falling edge
    // ****************************************
    logic [FALL_W-1:0] bin_reg;
    logic [FALL_W-1:0] gray_reg;
    logic [FALL_W-1:0] bin_next;

    assign bin_next = bin_reg + 5'h01;

    always_ff @(negedge sclk or posedge reset) begin
        if (reset) begin
            bin_reg <= '0;
            gray_reg <= '0;
        end else begin
            bin_reg <= bin_next;
            gray_reg <= bin_next ^ (bin_next >> 1);
        end
    end

    // ****************************************
    // core side: two-stage sync of the gray word
    // ****************************************
    // gray code changes one bit per edge, so a torn sample is off by one at most
    logic [FALL_W-1:0] gray_meta_reg;
    logic [FALL_W-1:0] gray_sync_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            gray_meta_reg <= '0;
            gray_sync_reg <= '0;
        end else begin
            gray_meta_reg <= gray_reg;
            gray_sync_reg <= gray_meta_reg;
        end
    end

    always_comb begin
        fall_count[FALL_W-1] = gray_sync_reg[FALL_W-1];
        for (int i = FALL_W - 2; i >= 0; i--) begin
            fall_count[i] = fall_count[i+1] ^ gray_sync_reg[i];
        end
    end

endmodule

//--- core/sadc_readout.sv
// conversion sequencing and three-wire serial readout of a 16-bit converter
//
// What this block does
// - start edge with input high selects chip-select
// - start edge with input low selects daisy-chain
// - busy option puts one busy bit first
// - start edge releases output, samples, converts
// - internal timer; start ignored while converting
// - serial clock only shifts result after conversion
// - conversion end: acquisition, power down, hold
// - result is 16-bit unsigned straight binary
// - start falling edge drives out the MSB
// - next bit after each serial clock fall
// - no busy: release after 16th fall or rise
// - start low at end drives busy bit low
// - busy: release after 17th fall or rise
`timescale 1ns/1ps
module sadc_readout
    import sadc_pkg::*;
(
    input wire logic mclk, // core clock, 250 MHz
    input wire logic reset, // async reset, active high
    input wire logic sclk, // serial clock from the host
    input wire logic conversion_start, // start pin, also chip select
    input wire logic serial_in, // serial input pin, mode select
    input wire logic [RESULT_W-1:0] conv_code, // settled code of the sar array
    output logic serial_out, // serial output data
    output logic serial_out_oe, // serial output driven when high
    output logic sample_strobe, // one-cycle pulse: sample the input
    output logic converter_powered, // conversion circuitry powered
    output logic [RESULT_W-1:0] result, // held conversion result
    output sadc_status_t status // sequencer status
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic din_meta_reg;
    logic din_sync_reg;
    logic din_prev_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            cs_meta_reg <= conversion_start;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            din_meta_reg <= 1'b1;
            din_sync_reg <= 1'b1;
            din_prev_reg <= 1'b1;
        end else begin
            din_meta_reg <= serial_in;
            din_sync_reg <= din_meta_reg;
            din_prev_reg <= din_sync_reg;
        end
    end

    logic cs_rise;
    logic cs_fall;

    assign cs_rise = cs_sync_reg & ~cs_prev_reg;
    assign cs_fall = ~cs_sync_reg & cs_prev_reg;

    // ****************************************
    // serial clock falls, crossed in gray code
    // ****************************************
    logic [FALL_W-1:0] fall_count;

    sadc_fall_counter u_falls (
        .mclk(mclk),
        .reset(reset),
        .sclk(sclk),
        .fall_count(fall_count)
    );

    // ****************************************
    // helpers
    // ****************************************
    // bit shown after a given number of falls within the frame
    function automatic logic pick_bit(
        input logic [RESULT_W-1:0] code,
        input logic busy,
        input logic [FALL_W-1:0] falls
    );
        logic [FALL_W-1:0] idx;
        idx = busy ? (BUSY_MSB_INDEX - falls) : (MSB_INDEX - falls);
        if (busy && falls == '0) begin
            pick_bit = BUSY_LEVEL;
        end else begin
            pick_bit = code[idx[3:0]];
        end
    endfunction

    function automatic logic [FALL_W-1:0] frame_len(input logic busy);
        frame_len = busy ? FRAME_BUSY : FRAME_PLAIN;
    endfunction

    // ****************************************
    // sequencer
    // ****************************************
    sadc_state_t state_reg;
    sadc_state_t state_next;
    logic [CONV_CNT_W-1:0] conv_cnt_reg;
    logic mode_cs_reg;
    logic busy_reg;
    logic [FALL_W-1:0] fall_base_reg;
    logic [FALL_W-1:0] frame_falls;
    logic frame_done;
    logic start_conv;
    logic conv_end;

    assign frame_falls = fall_count - fall_base_reg;
    assign frame_done = frame_falls >= frame_len(busy_reg);
    // a new start is honoured in every state but an active conversion
    assign start_conv = cs_rise && state_reg != ST_CONV;
    assign conv_end = state_reg == ST_CONV && conv_cnt_reg == CONV_LAST;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_conv) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_end) begin
                    if (!mode_cs_reg) begin
                        // daisy-chain readout is not carried by this block
                        state_next = ST_IDLE;
                    end else if (!cs_sync_reg) begin
                        state_next = ST_SHIFT;
                    end else begin
                        state_next = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (start_conv) begin
                    state_next = ST_CONV;
                end else if (cs_fall) begin
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (start_conv) begin
                    state_next = ST_CONV;
                end else if (frame_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // conversion timer runs from the core clock, pins cannot stretch it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            conv_cnt_reg <= '0;
        end else if (start_conv) begin
            conv_cnt_reg <= '0;
        end else if (state_reg == ST_CONV) begin
            conv_cnt_reg <= conv_cnt_reg + 8'h01;
        end
    end

    // mode taken from the input level just before the start edge, so an
    // input wired to the start pin reads low and selects daisy-chain
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mode_cs_reg <= 1'b1;
        end else if (start_conv) begin
            mode_cs_reg <= din_prev_reg;
        end
    end

    // busy option is set by a low start level seen when the conversion ends
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            busy_reg <= 1'b0;
        end else if (conv_end) begin
            busy_reg <= ~cs_sync_reg;
        end
    end

    // falls are only counted from the frame's first bit onward
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fall_base_reg <= '0;
        end else if (state_next == ST_SHIFT && state_reg != ST_SHIFT) begin
            fall_base_reg <= fall_count;
        end
    end

    // ****************************************
    // result hold
    // ****************************************
    logic [RESULT_W-1:0] result_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            result_reg <= RESULT_RESET;
        end else if (conv_end) begin
            result_reg <= conv_code;
        end
    end

    assign result = result_reg;

    // ****************************************
    // analog side controls
    // ****************************************
    logic sample_reg;
    logic powered_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= start_conv;
        end
    end

    // powered only while converting, down through acquisition
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            powered_reg <= 1'b0;
        end else begin
            powered_reg <= state_next == ST_CONV;
        end
    end

    assign sample_strobe = sample_reg;
    assign converter_powered = powered_reg;

    // ****************************************
    // serial output
    // ****************************************
    // one core cycle behind the sync, which keeps the old bit past the hold time
    sadc_pin_t pin_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_reg <= '0;
        end else if (state_reg == ST_SHIFT && !start_conv && !frame_done) begin
            pin_reg.drive <= 1'b1;
            pin_reg.data <= pick_bit(result_reg, busy_reg, frame_falls);
        end else begin
            pin_reg.drive <= 1'b0;
            pin_reg.data <= 1'b0;
        end
    end

    assign serial_out = pin_reg.data;
    assign serial_out_oe = pin_reg.drive;

    // ****************************************
    // status
    // ****************************************
    always_comb begin
        status.converting = state_reg == ST_CONV;
        status.acquiring = state_reg != ST_CONV;
        status.daisy_mode = ~mode_cs_reg;
        status.busy_option = busy_reg;
    end

endmodule

//--- test/sadc_host_model.sv
// host side model: serial clock bursts and capture of the output line
`timescale 1ns/1ps
module sadc_host_model (
    input wire logic run, // start a read burst
    input wire logic [4:0] nbits, // falling edges in one burst
    input wire logic line, // resolved serial output line
    output logic sclk, // serial clock, idles high
    output logic [16:0] word, // captured bits, first bit on the msb side
    output logic done // burst finished
);
    initial begin
        sclk = 1'b1;
        word = 17'h00000;
        done = 1'b0;
    end
    // clock stands still between bursts; odd offset keeps its falls off mclk edges, its rises land on mclk falling edges
    always @(posedge run) begin
        done = 1'b0;
        word = 17'h00000;
        repeat (nbits) begin
            #15 sclk = 1'b0;
            word = {word[15:0], line};
            #17 sclk = 1'b1;
        end
        done = 1'b1;
    end
endmodule

//--- test/sadc_readout_assertions.sv
// concurrent checks on the readout block ports
`timescale 1ns/1ps
module sadc_readout_checker
    import sadc_pkg::*;
(
    input wire logic mclk, // core clock
    input wire logic reset, // async reset
    input wire logic conversion_start, // start pin
    input wire logic [RESULT_W-1:0] conv_code, // sar code
    input wire logic serial_out, // output data
    input wire logic serial_out_oe, // output enable
    input wire logic sample_strobe, // sample pulse
    input wire logic converter_powered, // conversion power
    input wire logic [RESULT_W-1:0] result, // held result
    input wire sadc_status_t status // sequencer status
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic [7:0] pwr_cnt_reg;
    logic rdy_reg;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pwr_cnt_reg <= 8'h00;
        end else begin
            pwr_cnt_reg <= converter_powered ? pwr_cnt_reg + 8'h01 : 8'h00;
        end
    end
    // a fresh result waits for its readout until the next start
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdy_reg <= 1'b0;
        end else if (sample_strobe) begin
            rdy_reg <= 1'b0;
        end else if (!converter_powered && pwr_cnt_reg != 8'h00) begin
            rdy_reg <= 1'b1;
        end
    end
    sequence s_busy_end;
        $fell(converter_powered) && !conversion_start && !status.daisy_mode;
    endsequence
    sequence s_read_start;
        $fell(conversion_start) && rdy_reg && !status.daisy_mode && !status.busy_option
            && !serial_out_oe;
    endsequence
    AST_STROBE_PULSE: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe wider than one cycle");
    AST_START_RELEASE: assert property (sample_strobe |-> !serial_out_oe && converter_powered)
        else $error("start did not release output or power up");
    AST_CONV_LENGTH: assert property ($fell(converter_powered) |-> pwr_cnt_reg == 8'(CONV_CYCLES))
        else $error("conversion length wrong");
    AST_QUIET_CONV: assert property (converter_powered |-> !serial_out_oe)
        else $error("output driven during conversion");
    AST_POWER_DOWN: assert property ($fell(converter_powered) |-> ##[0:2] status.acquiring)
        else $error("no acquisition after conversion");
    AST_RESULT_CODE: assert property ($fell(converter_powered) |-> result == conv_code)
        else $error("result differs from converted code");
    AST_RESULT_HOLD: assert property ($changed(result) |-> $fell(converter_powered))
        else $error("result changed outside conversion end");
    AST_BUSY_BIT: assert property (s_busy_end |-> ##[1:4] serial_out_oe && !serial_out)
        else $error("busy bit missing");
    AST_MSB_OUT: assert property (s_read_start |-> ##[2:8] serial_out_oe && serial_out == result[15])
        else $error("msb not driven after start fall");
    AST_RISE_RELEASE: assert property ($rose(conversion_start) && serial_out_oe |-> ##[1:6] !serial_out_oe)
        else $error("start rise did not release output");
endmodule

bind sadc_readout sadc_readout_checker u_chk (.mclk(mclk), .reset(reset),
    .conversion_start(conversion_start), .conv_code(conv_code), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .sample_strobe(sample_strobe),
    .converter_powered(converter_powered), .result(result), .status(status));

//--- test/tb_top.sv
// self-checking testbench of the converter readout block
`timescale 1ns/1ps
module tb_top import sadc_pkg::*; ;
    logic mclk = 1'b0;
    logic reset = 1'b0;
    logic conversion_start = 1'b1;
    logic serial_in = 1'b1;
    logic [RESULT_W-1:0] conv_code = 16'h0000;
    logic run = 1'b0;
    logic [4:0] nbits = 5'h10;
    logic sclk, serial_out, serial_out_oe, sample_strobe, converter_powered, done, line;
    logic [RESULT_W:0] word;
    logic [RESULT_W-1:0] result;
    sadc_status_t status;
    int fail_count = 0;
    int checks_done = 0;
    always #2 mclk = ~mclk;
    assign line = serial_out_oe ? serial_out : 1'b1;
    sadc_readout uut (.mclk(mclk), .reset(reset), .sclk(sclk),
        .conversion_start(conversion_start), .serial_in(serial_in), .conv_code(conv_code),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .sample_strobe(sample_strobe),
        .converter_powered(converter_powered), .result(result), .status(status));
    sadc_host_model host (.run(run), .nbits(nbits), .line(line), .sclk(sclk), .word(word),
        .done(done));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [RESULT_W:0] exp,
        input logic [RESULT_W:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    // 0: output enable, 1: conversion power, 2: host burst done
    task automatic wait_for(input int sel, input logic lvl);
        logic s;
        for (int i = 0; i < 400; i++) begin
            @(negedge mclk);
            s = sel == 0 ? serial_out_oe : sel == 1 ? converter_powered : done;
            if (s === lvl) return;
        end
        fail_count++;
        $display("unexpected wait %0d: expected %b seen %b", sel, lvl, s);
        conclude();
    endtask
    // the start pulse during conversion must be ignored by the sequencer
    task automatic convert(input logic [RESULT_W-1:0] code, input logic mode, input logic busy);
        @(negedge mclk);
        conv_code = code;
        serial_in = mode;
        conversion_start = 1'b0;
        repeat (20) @(negedge mclk);
        conversion_start = 1'b1;
        repeat (20) @(negedge mclk);
        conversion_start = 1'b0;
        if (!busy) begin
            repeat (20) @(negedge mclk);
            conversion_start = 1'b1;
        end
        wait_for(1, 1'b0);
    endtask
    task automatic read(input logic [4:0] n);
        repeat (6) @(negedge mclk);
        nbits = n;
        run = 1'b1;
        wait_for(2, 1'b1);
        run = 1'b0;
    endtask
    task automatic t_plain();
        convert(16'ha5c3, 1'b1, 1'b0);
        chk("result", 17'h0a5c3, {1'b0, result});
        repeat (30) @(negedge mclk);
        conversion_start = 1'b0;
        wait_for(0, 1'b1);
        chk("msb", 17'h00001, {16'h0000, line});
        read(5'h10);
        chk("plain word", 17'h0a5c3, word);
        repeat (8) @(negedge mclk);
        chk("oe after 16", 17'h00000, {16'h0000, serial_out_oe});
        $display("test plain done");
    endtask
    task automatic t_busy();
        convert(16'h8001, 1'b1, 1'b1);
        wait_for(0, 1'b1);
        chk("busy bit", 17'h00000, {16'h0000, line});
        chk("busy flag", 17'h00001, {16'h0000, status.busy_option});
        read(5'h11);
        chk("busy word", 17'h08001, word);
        repeat (8) @(negedge mclk);
        chk("oe after 17", 17'h00000, {16'h0000, serial_out_oe});
        $display("test busy done");
    endtask
    task automatic t_abort();
        convert(16'h3c96, 1'b1, 1'b0);
        repeat (30) @(negedge mclk);
        conversion_start = 1'b0;
        wait_for(0, 1'b1);
        read(5'h04);
        chk("abort bits", 17'h00003, word);
        conversion_start = 1'b1;
        // release is due three core cycles after the pin rise
        repeat (4) @(negedge mclk);
        chk("oe at rise", 17'h00000, {16'h0000, serial_out_oe});
        chk("converting", 17'h00001, {16'h0000, status.converting});
        conv_code = 16'h5a0f;
        chk("held result", 17'h03c96, {1'b0, result});
        wait_for(1, 1'b0);
        chk("next result", 17'h05a0f, {1'b0, result});
        $display("test abort done");
    endtask
    task automatic t_daisy();
        convert(16'hffff, 1'b0, 1'b0);
        chk("daisy result", 17'h0ffff, {1'b0, result});
        chk("daisy mode", 17'h00001, {16'h0000, status.daisy_mode});
        repeat (40) @(negedge mclk);
        chk("daisy oe", 17'h00000, {16'h0000, serial_out_oe});
        $display("test daisy done");
    endtask
    initial begin
        // a real reset edge: the serial clock side only clears on it, sclk idles
        #1 reset = 1'b1;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        repeat (3) @(negedge mclk);
        t_plain();
        t_busy();
        t_abort();
        t_daisy();
        conclude();
    end
endmodule
